//--- pkg/timer8_pkg.sv
package timer8_pkg;

  // ----------------------------------------
  // Register map, byte addresses
  // ----------------------------------------
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_COUNT = 8'h04;
  localparam logic [7:0] OFS_COMPARE = 8'h08;
  localparam logic [7:0] OFS_FLAGS = 8'h0c;

  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int FORCE_BIT = 7;
  localparam int WAVE_LO_BIT = 6;
  localparam int COM_HI_BIT = 5;
  localparam int COM_LO_BIT = 4;
  localparam int WAVE_HI_BIT = 3;
  localparam int CS_HI_BIT = 2;
  localparam int FLAG_CMP_BIT = 1;
  localparam int FLAG_OVF_BIT = 0;

  // ----------------------------------------
  // Values and timing
  // ----------------------------------------
  localparam logic [7:0] TOP_FIXED = 8'hff;
  localparam logic [7:0] BOTTOM = 8'h00;
  localparam logic [7:0] COUNT_STEP = 8'h01;
  localparam int PRESCALE_WIDTH = 10;
  localparam logic [PRESCALE_WIDTH-1:0] PRE_STEP = 10'h001;
  localparam logic [PRESCALE_WIDTH-1:0] TAP_DIV8 = 10'h007;
  localparam logic [PRESCALE_WIDTH-1:0] TAP_DIV64 = 10'h03f;
  localparam logic [PRESCALE_WIDTH-1:0] TAP_DIV256 = 10'h0ff;
  localparam logic [PRESCALE_WIDTH-1:0] TAP_DIV1024 = 10'h3ff;
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic HRESP_OKAY = 1'h0;

  typedef enum logic [1:0] {
    MODE_FREE = 2'b00, MODE_PHASE = 2'b01, MODE_CLEAR = 2'b10, MODE_FAST = 2'b11
  } wave_mode_type;

  typedef enum logic [1:0] {
    COM_OFF = 2'b00, COM_TOGGLE = 2'b01, COM_CLEAR = 2'b10, COM_SET = 2'b11
  } out_mode_type;

  typedef enum logic [2:0] {
    CS_STOP = 3'b000, CS_DIRECT = 3'b001, CS_DIV8 = 3'b010, CS_DIV64 = 3'b011,
    CS_DIV256 = 3'b100, CS_DIV1024 = 3'b101, CS_EXT_FALL = 3'b110, CS_EXT_RISE = 3'b111
  } clk_src_type;

  typedef enum logic {BUS_IDLE = 1'b0, BUS_WAIT = 1'b1} bus_state_type;

  typedef struct packed {
    logic hsel;
    logic [31:0] haddr;
    logic [1:0] htrans;
    logic hwrite;
    logic [2:0] hsize;
    logic [31:0] hwdata;
    logic hready;
  } ahb_req_type;

  typedef struct packed {
    logic [31:0] hrdata;
    logic hreadyout;
    logic hresp;
  } ahb_rsp_type;

  typedef struct packed {
    bus_state_type busSt;
    logic [7:0] addr;
    logic wr;
    logic [31:0] rdata;
    logic ready;
    logic [6:0] ctrl;
    logic override;
    logic [7:0] count;
    logic [7:0] compare;
    logic [7:0] cmpActive;
    logic countDown;
    logic blockMatch;
    logic waveOut;
    logic cmpFlag;
    logic ovfFlag;
    logic [PRESCALE_WIDTH-1:0] pre;
    logic pinMeta;
    logic pinSync;
    logic pinPrev;
  } timer_state_type;

  localparam timer_state_type STATE_RESET = '{
    busSt: BUS_IDLE, addr: 8'h00, wr: 1'b0, rdata: 32'h0000_0000, ready: 1'b1,
    ctrl: 7'h00, override: 1'b0, count: 8'h00, compare: 8'h00, cmpActive: 8'h00,
    countDown: 1'b0, blockMatch: 1'b0, waveOut: 1'b0, cmpFlag: 1'b0, ovfFlag: 1'b0,
    pre: 10'h000, pinMeta: 1'b0, pinSync: 1'b0, pinPrev: 1'b0
  };

endpackage : timer8_pkg

//--- rtl/timer8_mode_compare_ctrl.sv
// The placing of the registers and the AHB-Lite register port were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none

// Function
// - Timer runs on the I/O clock; the tick is only a clock enable.
// - Force compare acts only in non-PWM modes.
// - Force compare applies a match action now, using the output mode written with it.
// - Force compare sets no flag and never clears the counter.
// - Force compare is a strobe and reads back as zero.
// - Wave mode field is split over control bits 6 and 3.
// - Mode decode sets TOP, compare update point and overflow point.
// - A nonzero output mode lets the compare output override the pin.
// - Non-PWM output modes: off, toggle, clear, set on match.
// - Fast PWM: off, reserved, clear/set on match, opposite at BOTTOM.
// - Phase PWM: off, reserved, action on up match, opposite on down match.
// - Phase PWM with compare at TOP and upper mode bit: act at TOP instead.
// - Clock select 0 stops, 1 direct, 2..5 prescaler taps 8..1024.
// - Clock select 6 counts falling, 7 rising edges of the count pin.
// - Count pin edges count even while that pin is an output.
// - Counter register is readable and writable; write replaces the count.
// - After a counter write, the match on the next tick is suppressed.
// - Match flag set on match, cleared by vector or by writing one.
// - Count pin edge reaches the counter 2 to 3 clocks later.
module timer8_mode_compare_ctrl (
  input wire logic clk,
  input wire logic sys_rst,
  input wire timer8_pkg::ahb_req_type busReq,
  output timer8_pkg::ahb_rsp_type busRsp,
  input wire logic extCountPin,
  input wire logic cmpVectorAck,
  input wire logic ovfVectorAck,
  output logic compareOutPin,
  output logic compareOutEn,
  output logic compareMatchFlag,
  output logic overflowFlag
);
  import timer8_pkg::*;

  timer_state_type q;
  timer_state_type d;

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic tapHit(input logic [PRESCALE_WIDTH-1:0] pre,
                                  input logic [PRESCALE_WIDTH-1:0] mask);
    tapHit = (pre & mask) == mask;
  endfunction : tapHit

  function automatic logic isPwm(input wave_mode_type mode);
    isPwm = (mode == MODE_PHASE) || (mode == MODE_FAST);
  endfunction : isPwm

  // Shared prescaler taps are free running, so the first tick lands 1..N clocks after enable
  function automatic logic tickSel(input clk_src_type sel,
                                   input logic [PRESCALE_WIDTH-1:0] pre,
                                   input logic sync,
                                   input logic prev);
    unique case (sel)
      CS_STOP: tickSel = 1'b0;
      CS_DIRECT: tickSel = 1'b1;
      CS_DIV8: tickSel = tapHit(pre, TAP_DIV8);
      CS_DIV64: tickSel = tapHit(pre, TAP_DIV64);
      CS_DIV256: tickSel = tapHit(pre, TAP_DIV256);
      CS_DIV1024: tickSel = tapHit(pre, TAP_DIV1024);
      CS_EXT_FALL: tickSel = prev && !sync;
      CS_EXT_RISE: tickSel = !prev && sync;
    endcase
  endfunction : tickSel

  function automatic logic matchAction(input wave_mode_type mode,
                                       input out_mode_type com,
                                       input logic down,
                                       input logic atTop,
                                       input logic cur);
    if (!isPwm(mode)) begin
      unique case (com)
        COM_OFF: matchAction = cur;
        COM_TOGGLE: matchAction = !cur;
        COM_CLEAR: matchAction = 1'b0;
        COM_SET: matchAction = 1'b1;
      endcase
    end else if (!com[1]) begin
      // Reserved code leaves the output alone
      matchAction = cur;
    end else if (mode == MODE_FAST) begin
      matchAction = com[0];
    end else if (!down || atTop) begin
      // Compare at TOP: act as the up-counting match at TOP
      matchAction = com[0];
    end else begin
      matchAction = !com[0];
    end
  endfunction : matchAction

  // ----------------------------------------
  // Decode of current state
  // ----------------------------------------
  wave_mode_type mode;
  out_mode_type com;
  clk_src_type clkSel;
  logic tick;
  logic matchNow;
  logic wrPhase;
  logic rdPhase;
  logic ctrlWr;
  logic countWr;
  logic flagWr;
  logic busTake;
  logic [31:0] wdata;
  wave_mode_type newMode;
  out_mode_type newCom;

  assign mode = wave_mode_type'({q.ctrl[WAVE_HI_BIT], q.ctrl[WAVE_LO_BIT]});
  assign com = out_mode_type'(q.ctrl[COM_HI_BIT:COM_LO_BIT]);
  assign clkSel = clk_src_type'(q.ctrl[CS_HI_BIT:0]);
  assign tick = tickSel(clkSel, q.pre, q.pinSync, q.pinPrev);
  assign matchNow = tick && (q.count == q.cmpActive) && !q.blockMatch;
  assign wdata = busReq.hwdata;
  assign wrPhase = (q.busSt == BUS_WAIT) && q.wr;
  assign rdPhase = (q.busSt == BUS_WAIT) && !q.wr;
  assign ctrlWr = wrPhase && (q.addr == OFS_CTRL);
  assign countWr = wrPhase && (q.addr == OFS_COUNT);
  assign flagWr = wrPhase && (q.addr == OFS_FLAGS);
  assign busTake = busReq.hsel && (busReq.htrans == HTRANS_NONSEQ) && busReq.hready;
  assign newMode = wave_mode_type'({wdata[WAVE_HI_BIT], wdata[WAVE_LO_BIT]});
  assign newCom = out_mode_type'(wdata[COM_HI_BIT:COM_LO_BIT]);

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    d = q;
    d.pre = q.pre + PRE_STEP;
    // Pin is sampled even when driven as an output
    d.pinMeta = extCountPin;
    d.pinSync = q.pinMeta;
    d.pinPrev = q.pinSync;

    // Clears first so that a same-cycle set wins
    if (cmpVectorAck || (flagWr && wdata[FLAG_CMP_BIT])) begin
      d.cmpFlag = 1'b0;
    end
    if (ovfVectorAck || (flagWr && wdata[FLAG_OVF_BIT])) begin
      d.ovfFlag = 1'b0;
    end

    if (!isPwm(mode)) begin
      d.cmpActive = q.compare;
    end else if (tick && (q.count == TOP_FIXED)) begin
      d.cmpActive = q.compare;
    end

    if (tick) begin
      d.blockMatch = 1'b0;
      unique case (mode)
        MODE_FREE, MODE_FAST: begin
          d.count = q.count + COUNT_STEP;
          if (q.count == TOP_FIXED) begin
            d.ovfFlag = 1'b1;
          end
        end
        MODE_CLEAR: begin
          d.count = matchNow ? BOTTOM : q.count + COUNT_STEP;
          if (q.count == TOP_FIXED) begin
            d.ovfFlag = 1'b1;
          end
        end
        MODE_PHASE: begin
          if (!q.countDown) begin
            if (q.count == TOP_FIXED) begin
              d.countDown = 1'b1;
              d.count = q.count - COUNT_STEP;
            end else begin
              d.count = q.count + COUNT_STEP;
            end
          end else if (q.count == BOTTOM) begin
            d.countDown = 1'b0;
            d.count = q.count + COUNT_STEP;
            d.ovfFlag = 1'b1;
          end else begin
            d.count = q.count - COUNT_STEP;
          end
        end
      endcase
      if (matchNow) begin
        d.cmpFlag = 1'b1;
        d.waveOut = matchAction(mode, com, q.countDown, q.cmpActive == TOP_FIXED,
                                q.waveOut);
      end
      // Bottom action after the match, so compare at MAX gives a steady level
      if (mode == MODE_FAST && q.count == TOP_FIXED && com[1]) begin
        d.waveOut = !com[0];
      end
    end

    // ----------------------------------------
    // Bus slave, one wait state per transfer
    // ----------------------------------------
    unique case (q.busSt)
      BUS_IDLE: begin
        if (busTake) begin
          d.busSt = BUS_WAIT;
          d.addr = busReq.haddr[7:0];
          d.wr = busReq.hwrite;
          d.ready = 1'b0;
        end
      end
      BUS_WAIT: begin
        d.busSt = BUS_IDLE;
        d.ready = 1'b1;
      end
    endcase

    if (rdPhase) begin
      unique case (q.addr)
        OFS_CTRL: d.rdata = {25'h0, q.ctrl};
        OFS_COUNT: d.rdata = {24'h0, q.count};
        OFS_COMPARE: d.rdata = {24'h0, q.compare};
        OFS_FLAGS: d.rdata = {30'h0, q.cmpFlag, q.ovfFlag};
        default: d.rdata = 32'h0000_0000;
      endcase
    end

    if (ctrlWr) begin
      d.ctrl = wdata[6:0];
      d.override = |wdata[COM_HI_BIT:COM_LO_BIT];
      // Strobe only: acts on output, no flag, no counter clear
      if (wdata[FORCE_BIT] && !isPwm(newMode)) begin
        d.waveOut = matchAction(newMode, newCom, 1'b0, 1'b0, d.waveOut);
      end
    end
    if (countWr) begin
      // Write beats a tick in the same cycle
      d.count = wdata[7:0];
      d.blockMatch = 1'b1;
    end
    if (wrPhase && (q.addr == OFS_COMPARE)) begin
      d.compare = wdata[7:0];
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      q <= STATE_RESET;
    end else begin
      q <= d;
    end
  end

  assign busRsp = '{hrdata: q.rdata, hreadyout: q.ready, hresp: HRESP_OKAY};
  assign compareOutPin = q.waveOut;
  assign compareOutEn = q.override;
  assign compareMatchFlag = q.cmpFlag;
  assign overflowFlag = q.ovfFlag;

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);

  logic extQuiet;
  assign extQuiet = (clkSel == CS_EXT_RISE) && (mode == MODE_FREE) && !wrPhase;

  sequence s_busWait;
    !busRsp.hreadyout ##1 busRsp.hreadyout;
  endsequence

  sequence s_extEdge;
    ($rose(extCountPin) && extQuiet) ##1 extQuiet ##1 extQuiet;
  endsequence

  property p_busAnswer;
    (q.busSt == BUS_IDLE && busTake) |=> s_busWait;
  endproperty
  a_busAnswer: assert property (p_busAnswer) else $error("bus answer late");

  property p_forceRead;
    (rdPhase && q.addr == OFS_CTRL) |=> (busRsp.hrdata[FORCE_BIT] == 1'b0);
  endproperty
  a_forceRead: assert property (p_forceRead) else $error("force bit read as one");

  property p_forceNoFlag;
    (ctrlWr && wdata[FORCE_BIT] && !matchNow && !cmpVectorAck)
      |=> (q.cmpFlag == $past(q.cmpFlag));
  endproperty
  a_forceNoFlag: assert property (p_forceNoFlag) else $error("force changed flag");

  property p_forceToggle;
    (ctrlWr && wdata[FORCE_BIT] && !isPwm(newMode) && newCom == COM_TOGGLE && !matchNow)
      |=> (compareOutPin != $past(compareOutPin));
  endproperty
  a_forceToggle: assert property (p_forceToggle) else $error("force did not toggle");

  property p_pwmNoForce;
    (ctrlWr && wdata[FORCE_BIT] && isPwm(newMode) && !tick) |=> $stable(compareOutPin);
  endproperty
  a_pwmNoForce: assert property (p_pwmNoForce) else $error("force acted in pwm");

  property p_override;
    ctrlWr |=> (compareOutEn == (|$past(wdata[COM_HI_BIT:COM_LO_BIT])));
  endproperty
  a_override: assert property (p_override) else $error("override wrong");

  property p_stopped;
    (clkSel == CS_STOP && !countWr) |=> $stable(q.count);
  endproperty
  a_stopped: assert property (p_stopped) else $error("stopped counter moved");

  property p_direct;
    (clkSel == CS_DIRECT && mode == MODE_FREE && !countWr)
      |=> (q.count == 8'($past(q.count) + COUNT_STEP));
  endproperty
  a_direct: assert property (p_direct) else $error("direct tick missed");

  property p_countWrite;
    countWr |=> (q.count == $past(wdata[7:0])) && q.blockMatch;
  endproperty
  a_countWrite: assert property (p_countWrite) else $error("count write lost");

  property p_block;
    (q.blockMatch && tick && !cmpVectorAck) |=> !$rose(q.cmpFlag);
  endproperty
  a_block: assert property (p_block) else $error("blocked match set flag");

  property p_matchFlag;
    matchNow |=> compareMatchFlag;
  endproperty
  a_matchFlag: assert property (p_matchFlag) else $error("match lost");

  property p_flagClear;
    (flagWr && wdata[FLAG_CMP_BIT] && !matchNow) |=> !compareMatchFlag;
  endproperty
  a_flagClear: assert property (p_flagClear) else $error("flag not cleared");

  property p_ctcClear;
    (matchNow && mode == MODE_CLEAR && !countWr) |=> (q.count == BOTTOM);
  endproperty
  a_ctcClear: assert property (p_ctcClear) else $error("clear on match failed");

  property p_extEdge;
    s_extEdge |-> ##[0:1] (q.count != $past(q.count));
  endproperty
  a_extEdge: assert property (p_extEdge) else $error("pin edge not counted");

  property p_reset;
    @(posedge clk) disable iff (1'b0)
      sys_rst |=> (q.ctrl == 7'h00) && (q.count == 8'h00) && !compareOutEn;
  endproperty
  a_reset: assert property (p_reset) else $error("reset state wrong");

endmodule : timer8_mode_compare_ctrl

`default_nettype wire

//--- testbench/tb_top.sv
`timescale 1ns/1ps
`default_nettype none

module tb_top;
  import timer8_pkg::*;

  logic clk;
  logic sys_rst;
  ahb_req_type busDrv;
  ahb_req_type busReq;
  ahb_rsp_type busRsp;
  logic extCountPin;
  logic cmpVectorAck;
  logic ovfVectorAck;
  logic compareOutPin;
  logic compareOutEn;
  logic compareMatchFlag;
  logic overflowFlag;
  logic rdPhase;
  logic [31:0] expQ[$];
  int fail_count = 0;
  int compares = 0;
  int cyc = 0;

  timer8_mode_compare_ctrl dut_u (
    .clk(clk),
    .sys_rst(sys_rst),
    .busReq(busReq),
    .busRsp(busRsp),
    .extCountPin(extCountPin),
    .cmpVectorAck(cmpVectorAck),
    .ovfVectorAck(ovfVectorAck),
    .compareOutPin(compareOutPin),
    .compareOutEn(compareOutEn),
    .compareMatchFlag(compareMatchFlag),
    .overflowFlag(overflowFlag)
  );

  // Single slave: its ready is the bus ready
  always_comb begin
    busReq = busDrv;
    busReq.hready = busRsp.hreadyout;
  end

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  always @(posedge clk) cyc <= cyc + 1;

  // ----------------------------------------
  // Checking and bus tasks
  // ----------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    compares++;
    if (seen !== exp) begin
      fail_count++;
      $display("[FAIL] %0t %s: seen %h expected %h", $time, what, seen, exp);
    end
  endtask : check

  task automatic complete_run;
    $display("comparisons %0d mismatches %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : complete_run

  // No wait limit here: only the watchdog ends a stalled transfer
  task automatic waitReady;
    do begin
      @(posedge clk);
    end while (busRsp.hreadyout !== 1'b1);
  endtask : waitReady

  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d);
    busDrv.haddr <= {24'h000000, a};
    busDrv.htrans <= HTRANS_NONSEQ;
    busDrv.hwrite <= wr;
    waitReady();
    busDrv.htrans <= 2'h0;
    busDrv.hwdata <= d;
    rdPhase <= ~wr;
    waitReady();
    rdPhase <= 1'b0;
  endtask : xfer

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    expQ.push_back(exp);
    xfer(1'b0, a, 32'h00000000);
  endtask : rd

  function automatic logic [31:0] ctl(input logic f, input logic [1:0] m,
      input logic [1:0] com, input logic [2:0] cs);
    return {24'h000000, f, m[0], com, m[1], cs};
  endfunction : ctl

  // Read data is judged where the data phase ends
  always @(posedge clk) begin
    if (rdPhase === 1'b1 && busRsp.hreadyout === 1'b1) begin
      check(busRsp.hrdata, expQ.pop_front(), "read data");
      check(busRsp.hresp, HRESP_OKAY, "response code");
    end
  end

  task automatic pwm(input logic [1:0] m, input logic [1:0] com, input logic [7:0] c,
      input int win, input int exp);
    int hi;
    hi = 0;
    wr(OFS_CTRL, 32'h00000000);
    wr(OFS_COMPARE, {24'h000000, c});
    wr(OFS_COUNT, 32'h00000000);
    wr(OFS_CTRL, ctl(1'b0, m, com, CS_DIRECT));
    repeat (2 * win) @(posedge clk);
    repeat (win) begin
      @(posedge clk);
      if (compareOutPin === 1'b1) hi++;
    end
    check(hi, exp, "output high time");
  endtask : pwm

  // ----------------------------------------
  // Watchdog
  // ----------------------------------------
  initial begin
    repeat (40000) @(posedge clk);
    fail_count++;
    $display("[FAIL] %0t watchdog expired", $time);
    complete_run();
  end

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    out_mode_type coms[5] = '{COM_SET, COM_CLEAR, COM_TOGGLE, COM_TOGGLE, COM_OFF};
    int divs[6] = '{0, 1, 8, 64, 256, 1024};
    logic [1:0] m;
    logic [1:0] com;
    logic [7:0] v;
    logic p;
    int k;
    int i;
    int t0;
    int span;
    sys_rst = 1'b1;
    busDrv = '0;
    busDrv.hsel = 1'b1;
    busDrv.hsize = 3'h2;
    extCountPin = 1'b0;
    cmpVectorAck = 1'b0;
    ovfVectorAck = 1'b0;
    rdPhase = 1'b0;
    k = $urandom(32'ha53943df);
    repeat (20) @(posedge clk);
    sys_rst <= 1'b0;
    rd(OFS_CTRL, 32'h00000000);
    rd(OFS_COUNT, 32'h00000000);
    check(compareOutEn, 1'b0, "output enable after reset");
    wr(8'h10, 32'hffffffff);
    rd(8'h10, 32'h00000000);
    $display("test reset and map done");
    for (i = 0; i < 3; i++) begin
      v = $urandom;
      wr(OFS_COUNT, {24'h000000, v});
      rd(OFS_COUNT, {24'h000000, v});
    end
    $display("test counter access done");
    wr(OFS_COUNT, 32'h00000033);
    wr(OFS_COMPARE, 32'h00000033);
    p = 1'b0;
    for (k = 0; k < 10; k++) begin
      m = (k < 5) ? MODE_FREE : MODE_CLEAR;
      com = coms[k % 5];
      wr(OFS_CTRL, ctl(1'b1, m, com, CS_STOP));
      case (com)
        COM_SET: p = 1'b1;
        COM_CLEAR: p = 1'b0;
        COM_TOGGLE: p = ~p;
        default: p = p;
      endcase
      if (com != COM_OFF) check(compareOutPin, p, "forced action");
      check(compareOutEn, com != COM_OFF, "pin override");
      check(compareMatchFlag, 1'b0, "flag after force");
      rd(OFS_CTRL, ctl(1'b0, m, com, CS_STOP));
    end
    rd(OFS_COUNT, 32'h00000033);
    for (k = 0; k < 2; k++) begin
      wr(OFS_CTRL, ctl(1'b1, MODE_FREE, COM_CLEAR, CS_STOP));
      check(compareOutPin, 1'b0, "forced clear");
      // Force written while a non-PWM mode is still selected
      wr(OFS_CTRL, ctl(1'b1, k ? MODE_FAST : MODE_PHASE, COM_SET, CS_STOP));
      check(compareOutPin, 1'b0, "force in pwm mode");
    end
    $display("test forced compare done");
    wr(OFS_CTRL, 32'h00000000);
    wr(OFS_COMPARE, 32'h00000005);
    wr(OFS_COUNT, 32'h00000005);
    wr(OFS_CTRL, ctl(1'b0, MODE_FREE, COM_OFF, CS_DIRECT));
    for (i = 0; i < 3; i++) begin
      k = 0;
      while ((i == 2 ? overflowFlag : compareMatchFlag) !== 1'b1 && k < 300) begin
        @(posedge clk);
        k++;
      end
      check(k < 300, 1'b1, "flag raised in time");
      if (i == 0) begin
        check(k > 240 && k < 300, 1'b1, "first match suppressed");
        check(overflowFlag, 1'b1, "overflow at max");
        wr(OFS_FLAGS, 32'h00000002);
        check(compareMatchFlag, 1'b0, "flag cleared by write");
        ovfVectorAck <= 1'b1;
        @(posedge clk);
        ovfVectorAck <= 1'b0;
        @(posedge clk);
        check(overflowFlag, 1'b0, "overflow cleared by vector");
      end else if (i == 1) begin
        cmpVectorAck <= 1'b1;
        @(posedge clk);
        cmpVectorAck <= 1'b0;
        @(posedge clk);
        check(compareMatchFlag, 1'b0, "flag cleared by vector");
      end else begin
        wr(OFS_FLAGS, 32'h00000001);
        check(overflowFlag, 1'b0, "overflow cleared by write");
      end
    end
    $display("test flags done");
    // Window between the two control writes is a whole number of tap periods
    for (i = 0; i < 6; i++) begin
      wr(OFS_CTRL, 32'h00000000);
      wr(OFS_COUNT, 32'h00000000);
      span = (i == 0) ? 40 : 8 * divs[i];
      t0 = cyc;
      wr(OFS_CTRL, ctl(1'b0, MODE_FREE, COM_OFF, i[2:0]));
      while (cyc < t0 + span) @(posedge clk);
      wr(OFS_CTRL, 32'h00000000);
      rd(OFS_COUNT, (i == 0) ? 32'h00000000 : 32'h00000008);
    end
    $display("test clock select done");
    for (i = 6; i < 8; i++) begin
      k = $urandom_range(9, 3);
      wr(OFS_COUNT, 32'h00000000);
      wr(OFS_CTRL, ctl(1'b0, MODE_FREE, COM_OFF, i[2:0]));
      repeat (4) @(posedge clk);
      repeat (k) begin
        extCountPin <= 1'b1;
        repeat (3) @(posedge clk);
        extCountPin <= 1'b0;
        repeat (3) @(posedge clk);
      end
      repeat (6) @(posedge clk);
      wr(OFS_CTRL, 32'h00000000);
      rd(OFS_COUNT, k);
    end
    $display("test count pin done");
    pwm(MODE_FAST, COM_CLEAR, 8'h80, 512, 258);
    pwm(MODE_FAST, COM_SET, 8'h80, 512, 254);
    pwm(MODE_FAST, COM_CLEAR, 8'hff, 512, 512);
    pwm(MODE_PHASE, COM_CLEAR, 8'h80, 1020, 512);
    pwm(MODE_PHASE, COM_SET, 8'h80, 1020, 508);
    pwm(MODE_CLEAR, COM_TOGGLE, 8'h09, 200, 100);
    $display("test waveforms done");
    complete_run();
  end

endmodule : tb_top

`default_nettype wire
